/* File: rtl/smmee_core.sv */
// Summary of operation
// - enter management mode only at an instruction boundary after a recognised request
// - optionally pulse a special bus cycle on entry and on exit
// - write the save image first, then fetch the handler
// - resume instruction reloads state and continues at the saved ip
// - handler fetch starts at base plus 08000h
// - save image spans base+FE00h..FFFFh, same layout in 32 and 64 bit
// - code segment from base[19:4], data selectors zero, GPRs untouched
// - flags forced to 0000_0002h on entry
// - CR0 bits 0,2,3,31 cleared, CR4 zeroed on entry
// - debug control forced to 0400h, debug status left alone
// - extended feature reg cleared except virtualization enable bit 12
// - NMI and INIT masked from entry while in management mode
// - address bit 20 mask input ignored while in management mode
// - real mode, 4G limits, 16-bit defaults, IP truncated to 16 bits
// - base at or above 0010_0000h makes code selector undefined
// - requests arrive only as fabric messages addressed by destination
// - local events issue a programmable I/O cycle to the hub instead
// - local source causes recorded in local status word at FEC4
// - trap word holds port in 31:16, breakpoint in 15:12, flags
// - trap valid bit 1 set only on I/O instruction boundary entry
// - trap bit 0 is 0 for write, 1 for read
// - image omits FP, MSRs, CR2; addresses stored canonical
// - restart byte zero on entry; FFh with valid trap replays I/O
// - halt bit reports halted entry; one on resume returns to halt
`timescale 1ns/1ps
`default_nettype none
module smmee_core
	import smmee_pkg::*;
#(
	parameter int ADDR_W = 32
) (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// fabric interrupt message
	input wire logic i_msg_valid,
	input wire logic i_msg_is_mgmt,
	input wire logic [7:0] i_msg_dest,
	input wire logic [7:0] i_core_id,
	// local sources: [3:0] io traps, [4] mce, [5] lvt legacy, [6] lvt ext
	input wire logic [6:0] i_local_src,
	input wire logic [15:0] i_trig_io_port,
	input wire logic [31:0] i_trig_io_data,
	output logic o_trig_io_valid,
	output logic [15:0] o_trig_io_port,
	output logic [31:0] o_trig_io_data,
	// pipeline
	input wire logic i_instr_boundary,
	input wire logic i_halted,
	input wire logic i_io_boundary,
	input wire logic [15:0] i_io_port,
	input wire logic [3:0] i_io_bp_match,
	input wire logic i_io_read,
	input wire logic [2:0] i_io_width,
	input wire logic i_io_rep,
	input wire logic i_io_str,
	input wire logic i_resume_instr,
	input wire logic i_addr_bit20_mask_in,
	// configuration
	input wire logic [31:0] i_mgmt_region_base,
	input wire logic i_entry_cycle_en,
	input wire logic i_exit_cycle_en,
	// architectural state in
	input wire logic [63:0] i_flags,
	input wire logic [63:0] i_ip,
	input wire logic [63:0] i_cr0,
	input wire logic [63:0] i_cr4,
	input wire logic [63:0] i_extended_feature_reg,
	input wire logic [63:0] i_virt_state,
	input wire logic [63:0] i_guest_cb,
	input wire logic [63:0] i_virt_ictl,
	// save-state memory port, one 64-bit word per acknowledged cycle
	output logic o_mem_wr,
	output logic o_mem_rd,
	output logic [ADDR_W-1:0] o_mem_addr,
	output logic [63:0] o_mem_wdata,
	input wire logic [63:0] i_mem_rdata,
	input wire logic i_mem_ack,
	// forced state
	output logic o_state_load,
	output logic [15:0] o_cs_sel,
	output logic o_cs_sel_undefined,
	output logic [15:0] o_data_sel,
	output logic [63:0] o_flags,
	output logic [63:0] o_cr0,
	output logic [63:0] o_cr4,
	output logic [63:0] o_debug_control_reg,
	output logic [63:0] o_extended_feature_reg,
	output logic [63:0] o_ip,
	output logic o_real_mode_16,
	output logic o_fetch_start,
	output logic [ADDR_W-1:0] o_fetch_addr,
	output logic o_in_mgmt_mode,
	output logic o_nmi_init_masked,
	output logic o_addr_bit20_mask,
	output logic o_resume_halt,
	output logic o_io_replay,
	output logic o_special_cycle,
	output logic o_special_exit
);

	smmee_state_e state_reg;
	logic [3:0] idx_reg;
	logic pend_reg;
	logic [31:0] trap_reg;
	logic [31:0] lsts_reg;
	logic [6:0] src_seen_reg;
	logic halt_reg;
	logic a20_s1_reg;
	logic a20_s2_reg;
	logic [63:0] saved_flags_ld_reg;
	logic [63:0] rip_ld_reg;
	logic [7:0] rbyte_ld_reg;
	logic [7:0] halt_ld_reg;
	logic [31:0] trap_ld_reg;
	logic msg_hit;
	logic [6:0] src_new;

	function automatic logic [63:0] canon(input logic [63:0] a);
		canon = {{16{a[47]}}, a[47:0]};
	endfunction : canon

	function automatic logic [15:0] word_ofs(input logic [3:0] i);
		case (i)
		4'd0: word_ofs = SMMEE_OFS_TRAP;
		4'd1: word_ofs = SMMEE_OFS_RBYTE;
		4'd2: word_ofs = SMMEE_OFS_EXTENDED_FEATURE_REG;
		4'd3: word_ofs = SMMEE_OFS_VSTATE;
		4'd4: word_ofs = SMMEE_OFS_GCBA;
		4'd5: word_ofs = SMMEE_OFS_VIC;
		4'd6: word_ofs = SMMEE_OFS_REV - 16'h0004;
		4'd7: word_ofs = SMMEE_OFS_BASE;
		4'd8: word_ofs = SMMEE_OFS_FLAGS;
		default: word_ofs = SMMEE_OFS_RIP;
		endcase
	endfunction : word_ofs

	assign msg_hit = i_msg_valid && i_msg_is_mgmt && i_msg_dest == i_core_id;
	assign src_new = i_local_src & ~src_seen_reg;

	// local sources only trigger an io cycle; the hub answers with a message
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			src_seen_reg <= 7'h00;
			o_trig_io_valid <= 1'b0;
			o_trig_io_port <= 16'h0000;
			o_trig_io_data <= 32'h0000_0000;
		end else begin
			o_trig_io_valid <= |src_new;
			o_trig_io_port <= i_trig_io_port;
			o_trig_io_data <= i_trig_io_data;
			src_seen_reg <= i_local_src;
		end
	end

	// sticky local causes; set wins over the clear done at resume
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			lsts_reg <= 32'h0000_0000;
		end else begin
			if (state_reg == SMMEE_EXIT)
				lsts_reg <= 32'h0000_0000;
			if (|src_new)
				lsts_reg <= lsts_reg | {14'h0000, src_new[6:5], 7'h00,
					src_new[4], 4'h0, src_new[3:0]};
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pend_reg <= 1'b0;
		end else begin
			if (state_reg == SMMEE_IDLE && i_instr_boundary)
				pend_reg <= 1'b0;
			if (msg_hit)
				pend_reg <= 1'b1;
		end
	end

	// the mask pin comes from outside, so two flops first
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			a20_s1_reg <= 1'b0;
			a20_s2_reg <= 1'b0;
		end else begin
			a20_s1_reg <= i_addr_bit20_mask_in;
			a20_s2_reg <= a20_s1_reg;
		end
	end
	assign o_addr_bit20_mask = a20_s2_reg && !o_in_mgmt_mode;

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_reg <= SMMEE_IDLE;
			idx_reg <= 4'd0;
			trap_reg <= 32'h0000_0000;
			halt_reg <= 1'b0;
		end else begin
			unique case (state_reg)
			SMMEE_IDLE: if (pend_reg && i_instr_boundary) begin
				state_reg <= SMMEE_SAVE;
				idx_reg <= 4'd0;
				halt_reg <= i_halted;
				trap_reg <= i_io_boundary ? {i_io_port, i_io_bp_match,
					i_flags[8], 4'h0, i_io_width, i_io_rep, i_io_str,
					1'b1, i_io_read} : 32'h0000_0000;
			end
			SMMEE_SAVE: if (i_mem_ack) begin
				if (idx_reg == 4'd9)
					state_reg <= SMMEE_RUN;
				idx_reg <= idx_reg + 4'd1;
			end
			SMMEE_RUN: if (i_resume_instr) begin
				state_reg <= SMMEE_LOAD;
				idx_reg <= 4'd0;
			end
			SMMEE_LOAD: if (i_mem_ack) begin
				if (idx_reg == 4'd3)
					state_reg <= SMMEE_EXIT;
				idx_reg <= idx_reg + 4'd1;
			end
			SMMEE_EXIT: state_reg <= SMMEE_IDLE;
			endcase
		end
	end

	// reload: trap word, restart/halt bytes, flags, ip
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			saved_flags_ld_reg <= 64'h0000_0000_0000_0000;
			rip_ld_reg <= 64'h0000_0000_0000_0000;
			rbyte_ld_reg <= 8'h00;
			halt_ld_reg <= 8'h00;
			trap_ld_reg <= 32'h0000_0000;
		end else if (state_reg == SMMEE_LOAD && i_mem_ack) begin
			unique case (idx_reg)
			4'd0: trap_ld_reg <= i_mem_rdata[31:0];
			4'd1: begin
				rbyte_ld_reg <= i_mem_rdata[7:0];
				halt_ld_reg <= i_mem_rdata[15:8];
			end
			4'd2: saved_flags_ld_reg <= i_mem_rdata;
			default: rip_ld_reg <= i_mem_rdata;
			endcase
		end
	end

	logic [63:0] wdata;
	always_comb begin
		unique case (idx_reg)
		4'd0: wdata = {lsts_reg, trap_reg};
		4'd1: wdata = {40'h00_0000_0000, 7'h00, o_in_mgmt_mode,
			7'h00, halt_reg, 8'h00};
		4'd2: wdata = i_extended_feature_reg;
		4'd3: wdata = i_virt_state;
		4'd4: wdata = canon(i_guest_cb);
		4'd5: wdata = i_virt_ictl;
		4'd6: wdata = {SMMEE_REV_ID, 32'h0000_0000};
		4'd7: wdata = {32'h0000_0000, i_mgmt_region_base};
		4'd8: wdata = i_flags;
		default: wdata = canon(i_ip);
		endcase
	end

	logic [15:0] ofs;
	always_comb begin
		ofs = (state_reg == SMMEE_LOAD) ? word_ofs(idx_reg == 4'd2 ? 4'd8 :
			idx_reg == 4'd3 ? 4'd9 : idx_reg) : word_ofs(idx_reg);
	end

	assign o_mem_wr = state_reg == SMMEE_SAVE;
	assign o_mem_rd = state_reg == SMMEE_LOAD;
	assign o_mem_addr = i_mgmt_region_base[ADDR_W-1:0] + {{(ADDR_W-16){1'b0}}, ofs};
	assign o_mem_wdata = wdata;
	assign o_in_mgmt_mode = state_reg != SMMEE_IDLE;
	assign o_nmi_init_masked = o_in_mgmt_mode;
	assign o_real_mode_16 = o_in_mgmt_mode;

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_state_load <= 1'b0;
			o_fetch_start <= 1'b0;
			o_fetch_addr <= '0;
			o_cs_sel <= 16'h0000;
			o_cs_sel_undefined <= 1'b0;
			o_data_sel <= 16'h0000;
			o_flags <= 64'h0000_0000_0000_0000;
			o_cr0 <= 64'h0000_0000_0000_0000;
			o_cr4 <= 64'h0000_0000_0000_0000;
			o_debug_control_reg <= 64'h0000_0000_0000_0000;
			o_extended_feature_reg <= 64'h0000_0000_0000_0000;
			o_ip <= 64'h0000_0000_0000_0000;
			o_resume_halt <= 1'b0;
			o_io_replay <= 1'b0;
			o_special_cycle <= 1'b0;
			o_special_exit <= 1'b0;
		end else begin
			o_state_load <= 1'b0;
			o_fetch_start <= 1'b0;
			o_special_cycle <= 1'b0;
			o_special_exit <= 1'b0;
			o_resume_halt <= 1'b0;
			o_io_replay <= 1'b0;
			if (state_reg == SMMEE_IDLE && pend_reg && i_instr_boundary)
				o_special_cycle <= i_entry_cycle_en;
			if (state_reg == SMMEE_SAVE && i_mem_ack && idx_reg == 4'd9) begin
				o_state_load <= 1'b1;
				o_fetch_start <= 1'b1;
				o_fetch_addr <= i_mgmt_region_base[ADDR_W-1:0] +
					{{(ADDR_W-16){1'b0}}, SMMEE_OFS_ENTRY};
				o_cs_sel <= i_mgmt_region_base[19:4];
				o_cs_sel_undefined <= i_mgmt_region_base >= SMMEE_HIGH_BASE;
				o_data_sel <= SMMEE_SEL_ZERO;
				o_flags <= SMMEE_FLAGS_INIT;
				o_cr0 <= i_cr0 & ~SMMEE_CR0_CLR;
				o_cr4 <= 64'h0000_0000_0000_0000;
				o_debug_control_reg <= SMMEE_DR7_INIT;
				o_extended_feature_reg <= i_extended_feature_reg & SMMEE_EXTENDED_FEATURE_REG_KEEP;
				o_ip <= {48'h0000_0000_0000, SMMEE_OFS_ENTRY};
			end
			if (state_reg == SMMEE_EXIT) begin
				o_state_load <= 1'b1;
				o_flags <= saved_flags_ld_reg;
				o_ip <= rip_ld_reg;
				o_resume_halt <= halt_ld_reg[0];
				o_io_replay <= trap_ld_reg[1] &&
					rbyte_ld_reg == SMMEE_RESTART_IO;
				o_special_exit <= i_exit_cycle_en;
			end
		end
	end

	property p_entry_boundary;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		(state_reg == SMMEE_IDLE ##1 state_reg == SMMEE_SAVE)
			|-> $past(i_instr_boundary) && $past(pend_reg);
	endproperty
	a_entry_boundary: assert property (p_entry_boundary)
		else $error("entry off boundary");

	property p_fetch_after_save;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		o_fetch_start |-> $past(state_reg) == SMMEE_SAVE && state_reg == SMMEE_RUN;
	endproperty
	a_fetch_after_save: assert property (p_fetch_after_save)
		else $error("fetch before save done");

	property p_fetch_addr;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		o_fetch_start |-> o_fetch_addr[15:0] == i_mgmt_region_base[15:0] + 16'h8000;
	endproperty
	a_fetch_addr: assert property (p_fetch_addr)
		else $error("wrong entry address");

	property p_forced_state;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		o_fetch_start |-> o_flags == 64'h2 && o_debug_control_reg == 64'h400
			&& o_cr4 == 64'h0 && o_data_sel == 16'h0;
	endproperty
	a_forced_state: assert property (p_forced_state)
		else $error("forced state wrong");

	property p_cr0_extended_feature_reg;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		o_fetch_start |-> (o_cr0 & 64'h8000_000d) == 64'h0
			&& (o_extended_feature_reg & ~64'h1000) == 64'h0;
	endproperty
	a_cr0_extended_feature_reg: assert property (p_cr0_extended_feature_reg)
		else $error("cr0 or feature bits kept");

	property p_nmi_mask;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		state_reg == SMMEE_SAVE |-> o_nmi_init_masked;
	endproperty
	a_nmi_mask: assert property (p_nmi_mask)
		else $error("nmi not masked");

	property p_a20_ignored;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		o_in_mgmt_mode |-> !o_addr_bit20_mask;
	endproperty
	a_a20_ignored: assert property (p_a20_ignored)
		else $error("a20 mask active");

	property p_save_range;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		o_mem_wr |-> ofs >= SMMEE_SAVE_LO;
	endproperty
	a_save_range: assert property (p_save_range)
		else $error("save outside region");

	property p_trap_valid;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		$rose(o_mem_wr) |-> trap_reg[1] == $past(i_io_boundary);
	endproperty
	a_trap_valid: assert property (p_trap_valid)
		else $error("trap valid wrong");

	property p_local_trig;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		(|src_new) |=> o_trig_io_valid && lsts_reg != 32'h0;
	endproperty
	a_local_trig: assert property (p_local_trig)
		else $error("no trigger io cycle");

	c_entry: cover property (@(posedge i_sys_clk) o_fetch_start);
	c_exit: cover property (@(posedge i_sys_clk) state_reg == SMMEE_EXIT);
	c_replay: cover property (@(posedge i_sys_clk) o_io_replay);
	c_halt: cover property (@(posedge i_sys_clk) o_resume_halt);

endmodule : smmee_core
`default_nettype wire

/* File: pkg/smmee_pkg.sv */
`default_nettype none
package smmee_pkg;
	localparam logic [15:0] SMMEE_OFS_TRAP = 16'hfec0;
	localparam logic [15:0] SMMEE_OFS_LSTS = 16'hfec4;
	localparam logic [15:0] SMMEE_OFS_RBYTE = 16'hfec8;
	localparam logic [15:0] SMMEE_OFS_HALT = 16'hfec9;
	localparam logic [15:0] SMMEE_OFS_NMIM = 16'hfeca;
	localparam logic [15:0] SMMEE_OFS_EXTENDED_FEATURE_REG = 16'hfed0;
	localparam logic [15:0] SMMEE_OFS_VSTATE = 16'hfed8;
	localparam logic [15:0] SMMEE_OFS_GCBA = 16'hfee0;
	localparam logic [15:0] SMMEE_OFS_VIC = 16'hfee8;
	localparam logic [15:0] SMMEE_OFS_REV = 16'hfefc;
	localparam logic [15:0] SMMEE_OFS_BASE = 16'hff00;
	localparam logic [15:0] SMMEE_OFS_FLAGS = 16'hff70;
	localparam logic [15:0] SMMEE_OFS_RIP = 16'hff78;
	localparam logic [15:0] SMMEE_OFS_ENTRY = 16'h8000;
	localparam logic [15:0] SMMEE_SAVE_LO = 16'hfe00;
	localparam logic [15:0] SMMEE_SAVE_HI = 16'hffff;
	localparam logic [63:0] SMMEE_FLAGS_INIT = 64'h0000_0000_0000_0002;
	localparam logic [63:0] SMMEE_DR7_INIT = 64'h0000_0000_0000_0400;
	localparam logic [63:0] SMMEE_CR0_CLR = 64'h0000_0000_8000_000d;
	localparam logic [63:0] SMMEE_EXTENDED_FEATURE_REG_KEEP = 64'h0000_0000_0000_1000;
	localparam logic [31:0] SMMEE_HIGH_BASE = 32'h0010_0000;
	localparam logic [7:0] SMMEE_RESTART_IO = 8'hff;
	localparam logic [31:0] SMMEE_REV_ID = 32'h0003_0064;
	localparam logic [31:0] SMMEE_BASE_RST = 32'h0003_0000;
	localparam logic [15:0] SMMEE_SEL_ZERO = 16'h0000;
	localparam int SMMEE_NWORDS = 13;
	typedef enum logic [4:0] {
		SMMEE_IDLE = 5'b00001,
		SMMEE_SAVE = 5'b00010,
		SMMEE_RUN = 5'b00100,
		SMMEE_LOAD = 5'b01000,
		SMMEE_EXIT = 5'b10000
	} smmee_state_e;
endpackage : smmee_pkg
`default_nettype wire

/* File: test/smmee_save_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module smmee_save_mem (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_slow,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] i_addr,
	input wire logic [63:0] i_wdata,
	output logic o_ack,
	output logic [63:0] o_rdata
);
	logic [63:0] mem_reg [logic [31:0]];
	logic [63:0] last_reg;
	logic [63:0] rd_word;
	logic [1:0] wait_reg;
	// slow mode makes the core hold each word for three cycles
	assign o_ack = (i_wr | i_rd) & (!i_slow | wait_reg == 2'h2);
	always_comb begin
		rd_word = mem_reg.exists(i_addr) ? mem_reg[i_addr] : 64'h0;
	end
	// idle read bus shows the inverse of the last word, never a stale copy
	assign o_rdata = (o_ack & i_rd) ? rd_word : ~last_reg;
	always @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wait_reg <= 2'h0;
			last_reg <= 64'h0;
		end else if (o_ack) begin
			wait_reg <= 2'h0;
			if (i_wr) begin
				mem_reg[i_addr] = i_wdata;
			end
			if (i_rd) begin
				last_reg <= rd_word;
			end
		end else if (i_wr | i_rd) begin
			wait_reg <= wait_reg + 2'h1;
		end
	end
	// handler side writes into the save image
	task automatic poke(input logic [31:0] a, input logic [63:0] d);
		mem_reg[a] = d;
	endtask : poke
endmodule : smmee_save_mem
`default_nettype wire

/* File: test/tb_system_mgmt_mode_entry_exit.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_system_mgmt_mode_entry_exit;
	import smmee_pkg::*;
	typedef struct {
		logic [31:0] base;
		logic io, rd, halted, en, sl, hb;
		logic [2:0] w;
		logic [6:0] src;
		logic [7:0] rb;
	} smmee_row_s;
	logic i_sys_clk, i_resetn, i_msg_valid, i_msg_is_mgmt, i_instr_boundary;
	logic i_halted, i_io_boundary, i_io_read, i_io_rep, i_io_str, i_mem_ack;
	logic i_resume_instr, i_addr_bit20_mask_in, i_entry_cycle_en;
	logic i_exit_cycle_en, slow;
	logic [7:0] i_msg_dest, i_core_id;
	logic [6:0] i_local_src;
	logic [15:0] i_trig_io_port, i_io_port, o_trig_io_port, o_cs_sel, o_data_sel;
	logic [31:0] i_trig_io_data, i_mgmt_region_base;
	logic [31:0] o_trig_io_data, o_mem_addr, o_fetch_addr;
	logic [3:0] i_io_bp_match;
	logic [2:0] i_io_width;
	logic [63:0] i_flags, i_ip, i_cr0, i_cr4, i_extended_feature_reg;
	logic [63:0] i_virt_state, i_guest_cb, i_virt_ictl, i_mem_rdata;
	logic [63:0] o_mem_wdata, o_flags, o_cr0, o_cr4, o_debug_control_reg;
	logic [63:0] o_extended_feature_reg, o_ip;
	logic o_trig_io_valid, o_mem_wr, o_mem_rd, o_state_load, o_cs_sel_undefined;
	logic o_real_mode_16, o_fetch_start, o_in_mgmt_mode, o_nmi_init_masked;
	logic o_addr_bit20_mask, o_resume_halt, o_io_replay, o_special_cycle;
	logic o_special_exit;
	int failures, comparisons, sc, se;
	logic [31:0] aq [$];
	logic [63:0] dq [$];
	localparam logic [15:0] OFS [10] = '{16'hfec0, 16'hfec8, 16'hfed0,
		16'hfed8, 16'hfee0, 16'hfee8, 16'hfef8, 16'hff00, 16'hff70, 16'hff78};
	smmee_row_s rows [3] = '{
		'{32'h0003_0000, 1, 1, 0, 1, 0, 1, 3'h4, 7'h01, 8'hff},
		'{32'h0010_0100, 0, 0, 1, 0, 1, 1, 3'h2, 7'h10, 8'hff},
		'{32'h000a_8100, 1, 0, 0, 1, 1, 0, 3'h1, 7'h60, 8'h00}
	};
	smmee_core u_dut (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
		.i_msg_valid(i_msg_valid), .i_msg_is_mgmt(i_msg_is_mgmt),
		.i_msg_dest(i_msg_dest), .i_core_id(i_core_id),
		.i_local_src(i_local_src), .i_trig_io_port(i_trig_io_port),
		.i_trig_io_data(i_trig_io_data), .o_trig_io_valid(o_trig_io_valid),
		.o_trig_io_port(o_trig_io_port), .o_trig_io_data(o_trig_io_data),
		.i_instr_boundary(i_instr_boundary), .i_halted(i_halted),
		.i_io_boundary(i_io_boundary), .i_io_port(i_io_port),
		.i_io_bp_match(i_io_bp_match), .i_io_read(i_io_read),
		.i_io_width(i_io_width), .i_io_rep(i_io_rep), .i_io_str(i_io_str),
		.i_resume_instr(i_resume_instr),
		.i_addr_bit20_mask_in(i_addr_bit20_mask_in),
		.i_mgmt_region_base(i_mgmt_region_base),
		.i_entry_cycle_en(i_entry_cycle_en),
		.i_exit_cycle_en(i_exit_cycle_en),
		.i_flags(i_flags), .i_ip(i_ip), .i_cr0(i_cr0), .i_cr4(i_cr4),
		.i_extended_feature_reg(i_extended_feature_reg),
		.i_virt_state(i_virt_state), .i_guest_cb(i_guest_cb),
		.i_virt_ictl(i_virt_ictl), .o_mem_wr(o_mem_wr), .o_mem_rd(o_mem_rd),
		.o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
		.i_mem_rdata(i_mem_rdata), .i_mem_ack(i_mem_ack),
		.o_state_load(o_state_load), .o_cs_sel(o_cs_sel),
		.o_cs_sel_undefined(o_cs_sel_undefined), .o_data_sel(o_data_sel),
		.o_flags(o_flags), .o_cr0(o_cr0), .o_cr4(o_cr4),
		.o_debug_control_reg(o_debug_control_reg),
		.o_extended_feature_reg(o_extended_feature_reg), .o_ip(o_ip),
		.o_real_mode_16(o_real_mode_16), .o_fetch_start(o_fetch_start),
		.o_fetch_addr(o_fetch_addr), .o_in_mgmt_mode(o_in_mgmt_mode),
		.o_nmi_init_masked(o_nmi_init_masked),
		.o_addr_bit20_mask(o_addr_bit20_mask),
		.o_resume_halt(o_resume_halt), .o_io_replay(o_io_replay),
		.o_special_cycle(o_special_cycle), .o_special_exit(o_special_exit));
	smmee_save_mem u_mem (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
		.i_slow(slow), .i_wr(o_mem_wr), .i_rd(o_mem_rd), .i_addr(o_mem_addr),
		.i_wdata(o_mem_wdata), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
	always #25 i_sys_clk = ~i_sys_clk;
	always @(posedge i_sys_clk) begin
		if (o_mem_wr && i_mem_ack) begin
			aq.push_back(o_mem_addr);
			dq.push_back(o_mem_wdata);
		end
	end
	always @(negedge i_sys_clk) begin
		sc += int'(o_special_cycle);
		se += int'(o_special_exit);
	end
	task automatic cmp(input logic [63:0] got, exp, input string what);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : cmp
	task automatic cmp_bit(input logic got, exp, input string what);
		cmp({63'h0, got}, {63'h0, exp}, what);
	endtask : cmp_bit
	task automatic complete_run;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : complete_run
	// 0 fetch start, 1 state load, 2 save write
	function automatic logic pick(input int sel);
		pick = sel == 0 ? o_fetch_start : sel == 1 ? o_state_load : o_mem_wr;
	endfunction : pick
	// bounded wait, ends on a falling edge with the signal settled
	task automatic wait_hi(input int sel, input string what);
		int n;
		n = 0;
		@(negedge i_sys_clk);
		while (pick(sel) !== 1'b1 && n < 200) begin
			@(negedge i_sys_clk);
			n++;
		end
		cmp_bit(pick(sel), 1'b1, what);
	endtask : wait_hi
	task automatic run_row(input smmee_row_s r);
		logic [63:0] v;
		logic [63:0] cv;
		logic [63:0] m [10];
		logic [63:0] e [10];
		v = {~r.base, r.base};
		// stored addresses are sign-extended from bit 47
		cv = {{16{~v[47]}}, ~v[47:0]};
		m = '{r.io ? '1 : 64'hffff_ffff_0000_0002, 64'h0000_0000_0000_ffff, '1,
			'1, '1, '1, 64'hffff_ffff_0000_0000, 64'h0000_0000_ffff_ffff, '1, '1};
		e = '{{14'h0, r.src[6:5], 7'h0, r.src[4], 4'h0, r.src[3:0],
			~r.base[15:0], r.base[19:16], r.base[8], 4'h0, r.w, r.rd, r.halted,
			r.io, r.rd}, {48'h0, 7'h0, r.halted, 8'h00}, ~v, v, cv, v,
			{32'h0003_0064, 32'h0}, {32'h0, r.base}, v, cv};
		sc = 0;
		se = 0;
		aq.delete();
		dq.delete();
		@(posedge i_sys_clk);
		i_mgmt_region_base <= r.base;
		{i_entry_cycle_en, i_exit_cycle_en, slow} <= {r.en, r.en, r.sl};
		{i_io_boundary, i_io_read, i_halted, i_io_width} <= {r.io, r.rd,
			r.halted, r.w};
		{i_io_port, i_io_bp_match} <= {~r.base[15:0], r.base[19:16]};
		{i_io_rep, i_io_str} <= {r.rd, r.halted};
		{i_trig_io_port, i_trig_io_data} <= {~r.base[15:0], ~r.base};
		{i_flags, i_cr0, i_cr4, i_virt_state, i_virt_ictl} <= {5{v}};
		{i_ip, i_extended_feature_reg, i_guest_cb} <= {3{~v}};
		i_local_src <= r.src;
		@(posedge i_sys_clk);
		@(negedge i_sys_clk);
		cmp_bit(o_trig_io_valid, 1'b1, "trigger pulse");
		cmp({o_trig_io_port, o_trig_io_data}, {16'h0, ~r.base[15:0], ~r.base},
			"trigger cycle");
		@(negedge i_sys_clk);
		cmp_bit(o_trig_io_valid, 1'b0, "trigger width");
		@(posedge i_sys_clk);
		{i_msg_valid, i_msg_is_mgmt, i_msg_dest} <= {2'h3, 8'h03};
		repeat (3) @(negedge i_sys_clk);
		cmp_bit(o_in_mgmt_mode, 1'b0, "entry off boundary");
		@(posedge i_sys_clk);
		i_msg_valid <= 1'b0;
		i_instr_boundary <= 1'b1;
		wait_hi(0, "handler fetch");
		cmp(64'(aq.size()), 64'h0000_0000_0000_000a, "saves first");
		cmp_bit(o_state_load, 1'b1, "forced state");
		cmp({32'h0, o_fetch_addr}, {32'h0, r.base + 32'h0000_8000}, "entry");
		cmp(o_ip, 64'h0000_0000_0000_8000, "entry ip");
		cmp({o_cs_sel, o_data_sel}, {32'h0, r.base[19:4], 16'h0}, "sel");
		cmp_bit(o_cs_sel_undefined, r.base >= 32'h0010_0000, "cs undef");
		cmp(o_flags, 64'h0000_0000_0000_0002, "flags");
		cmp(o_cr0, v & ~64'h0000_0000_8000_000d, "cr0");
		cmp(o_cr4, 64'h0, "cr4");
		cmp(o_debug_control_reg, 64'h0000_0000_0000_0400, "dr7");
		cmp(o_extended_feature_reg, ~v & 64'h0000_0000_0000_1000, "extended_feature_reg");
		cmp({61'h0, o_in_mgmt_mode, o_nmi_init_masked, o_real_mode_16},
			64'h0000_0000_0000_0007, "mode");
		cmp(64'(sc), {63'h0, r.en}, "entry cycle");
		for (int i = 0; i < 10; i++) begin
			cmp({32'h0, aq[i]}, {32'h0, r.base + {16'h0, OFS[i]}}, "addr");
			cmp(dq[i] & m[i], e[i] & m[i], "word");
		end
		@(posedge i_sys_clk);
		i_instr_boundary <= 1'b0;
		i_addr_bit20_mask_in <= 1'b1;
		repeat (4) @(negedge i_sys_clk);
		cmp_bit(o_addr_bit20_mask, 1'b0, "a20 in mode");
		u_mem.poke(r.base + 32'h0000_fec8, {48'h0, 7'h0, r.hb, r.rb});
		u_mem.poke(r.base + 32'h0000_ff70, ~v);
		@(posedge i_sys_clk);
		i_resume_instr <= 1'b1;
		@(posedge i_sys_clk);
		i_resume_instr <= 1'b0;
		wait_hi(1, "reload");
		cmp(o_flags, ~v, "restored flags");
		cmp(o_ip, cv, "restored ip");
		cmp_bit(o_io_replay, r.io & (r.rb == 8'hff), "replay");
		cmp_bit(o_resume_halt, r.hb, "halt return");
		repeat (3) @(negedge i_sys_clk);
		cmp(64'(se), {63'h0, r.en}, "exit cycle");
		cmp_bit(o_in_mgmt_mode, 1'b0, "left mode");
		cmp_bit(o_addr_bit20_mask, 1'b1, "a20 outside");
		@(posedge i_sys_clk);
		i_addr_bit20_mask_in <= 1'b0;
		i_local_src <= 7'h00;
	endtask : run_row
	initial begin
		repeat (6000) @(posedge i_sys_clk);
		failures++;
		complete_run();
	end
	initial begin
		i_sys_clk = 1'b0;
		{i_resetn, i_msg_valid, i_msg_is_mgmt, i_msg_dest, i_local_src,
			i_trig_io_port, i_trig_io_data, i_instr_boundary, i_halted,
			i_io_boundary, i_io_port, i_io_bp_match, i_io_read, i_io_width,
			i_io_rep, i_io_str, i_resume_instr, i_addr_bit20_mask_in,
			i_mgmt_region_base, i_entry_cycle_en, i_exit_cycle_en, slow} = '0;
		{i_flags, i_ip, i_cr0, i_cr4, i_extended_feature_reg, i_virt_state,
			i_guest_cb, i_virt_ictl} = '0;
		i_core_id = 8'h03;
		repeat (10) @(negedge i_sys_clk);
		cmp({59'h0, o_mem_wr, o_in_mgmt_mode, o_fetch_start, o_special_cycle,
			o_trig_io_valid}, 64'h0, "reset outputs");
		repeat (10) @(posedge i_sys_clk);
		i_resetn <= 1'b1;
		foreach (rows[k]) begin
			run_row(rows[k]);
		end
		@(posedge i_sys_clk);
		{i_msg_valid, i_msg_is_mgmt, i_instr_boundary} <= 3'h7;
		i_msg_dest <= 8'h05;
		repeat (5) @(negedge i_sys_clk);
		cmp_bit(o_in_mgmt_mode, 1'b0, "foreign dest");
		@(posedge i_sys_clk);
		i_msg_dest <= 8'h03;
		wait_hi(2, "save start");
		@(posedge i_sys_clk);
		i_resetn <= 1'b0;
		i_msg_valid <= 1'b0;
		@(negedge i_sys_clk);
		cmp({62'h0, o_mem_wr, o_in_mgmt_mode}, 64'h0, "reset abort");
		@(posedge i_sys_clk);
		i_resetn <= 1'b1;
		repeat (5) @(negedge i_sys_clk);
		cmp_bit(o_in_mgmt_mode, 1'b0, "no stale request");
		complete_run();
	end
endmodule : tb_system_mgmt_mode_entry_exit
`default_nettype wire
